// ===== src/lnb_tone_burst_modulator.sv
/*
  Tone modulator for LNB control: register port, byte queue, symbol sequencer and
  pin driver with static, burst and continuous tone modes.
  Assumes the register port strobes are one cycle wide and synchronous to sys_clk.
*/
`timescale 1ns/1ps
module lnb_tone_burst_modulator #(
  parameter int HALF_PERIOD_CYCLES = tone_pkg::HALF_PERIOD_CYCLES
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Tone pin
  output logic            tone_out,
  output logic            tone_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and queue
  logic [1:0]  output_mode_field_reg;
  logic        zero_shape_select_reg;
  logic [7:0]  reg_rdata_reg;
  logic        queue_empty_flag;
  logic        queue_full_flag;

  tone_fifo_if q ();

  tone_fifo u_fifo (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .q       (q.store)
  );

  assign queue_empty_flag = q.empty;
  assign queue_full_flag  = q.full;

  // Writes while full are dropped inside the queue
  assign q.push      = reg_wr && (reg_addr == tone_pkg::FIFO_OFFSET); // [R12]
  assign q.push_data = reg_wdata;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_mode_field_reg <= tone_pkg::MODE_RESET;
      zero_shape_select_reg <= tone_pkg::ZERO_SHAPE_RESET;
    end else if (reg_wr && (reg_addr == tone_pkg::CTRL_OFFSET)) begin
      output_mode_field_reg <= reg_wdata[tone_pkg::MODE_LSB +: 2];
      zero_shape_select_reg <= reg_wdata[tone_pkg::ZERO_SHAPE_BIT];
    end
  end

  tone_pkg::tx_state_t state_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == tone_pkg::CTRL_OFFSET) begin
        reg_rdata_reg <= {5'h00, zero_shape_select_reg, output_mode_field_reg};
      end else if (reg_addr == tone_pkg::STATUS_OFFSET) begin
        reg_rdata_reg <= {5'h00, (state_reg == tone_pkg::TX_SEND),
                          queue_full_flag, queue_empty_flag}; // [R12] [R13]
      end else begin
        // Queue register is write only; unmapped reads return zero
        reg_rdata_reg <= 8'h00;
      end
    end
  end

  assign reg_rdata = reg_rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Tone clock: square wave from the system clock
  logic [15:0] half_cnt_reg;
  logic        half_tick;
  logic        tone_phase_reg;
  logic        period_tick;

  assign half_tick   = (half_cnt_reg == 16'(HALF_PERIOD_CYCLES - 1));
  // One tone period ends on each falling edge of the phase
  assign period_tick = half_tick && tone_phase_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt_reg   <= 16'h0000;
      tone_phase_reg <= 1'b0;
    end else if (half_tick) begin
      half_cnt_reg   <= 16'h0000;
      tone_phase_reg <= ~tone_phase_reg; // [R1] [R9]
    end else begin
      half_cnt_reg <= half_cnt_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Symbol sequencer
  logic [8:0]  shift_reg;
  logic [3:0]  bit_idx_reg;
  logic [5:0]  period_cnt_reg;
  logic        load_symbol;
  logic        last_period;
  logic        last_bit;
  logic        bit_gate;

  assign last_period = (period_cnt_reg == tone_pkg::BIT_PERIODS - 6'd1); // [R3]
  assign last_bit    = (bit_idx_reg == tone_pkg::SYMBOL_BITS - 4'd1);
  // Next byte starts on the following period with no gap
  assign load_symbol = period_tick && !queue_empty_flag &&
                       ((state_reg == tone_pkg::TX_IDLE) ||
                        (last_period && last_bit)); // [R13] [R15]
  assign q.pop       = load_symbol;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= tone_pkg::TX_IDLE;
    end else if (period_tick) begin
      case (state_reg)
        tone_pkg::TX_IDLE: begin
          if (load_symbol) begin
            state_reg <= tone_pkg::TX_SEND;
          end
        end
        tone_pkg::TX_SEND: begin
          if (last_period && last_bit && !load_symbol) begin
            state_reg <= tone_pkg::TX_IDLE; // [R14]
          end
        end
        default: begin
          state_reg <= tone_pkg::TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg      <= 9'h000;
      bit_idx_reg    <= 4'h0;
      period_cnt_reg <= 6'h00;
    end else if (load_symbol) begin
      // Data MSB first, then a parity bit making the ones count odd
      shift_reg      <= {q.pop_data, ~(^q.pop_data)}; // [R2] [R7] [R8]
      bit_idx_reg    <= 4'h0;
      period_cnt_reg <= 6'h00;
    end else if (period_tick && (state_reg == tone_pkg::TX_SEND)) begin
      if (last_period) begin
        period_cnt_reg <= 6'h00;
        bit_idx_reg    <= bit_idx_reg + 4'h1;
        shift_reg      <= {shift_reg[7:0], 1'b0};
      end else begin
        period_cnt_reg <= period_cnt_reg + 6'h01; // [R3]
      end
    end
  end

  // Pulse width shaping of the current bit
  always_comb begin
    if (shift_reg[8]) begin
      bit_gate = (period_cnt_reg < tone_pkg::SHORT_PERIODS); // [R6] [R7]
    end else if (zero_shape_select_reg) begin
      bit_gate = (period_cnt_reg < tone_pkg::LONG_PERIODS); // [R4]
    end else begin
      bit_gate = 1'b1; // [R5] [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin driver
  logic tone_out_reg;
  logic tone_oe_reg;
  logic sending;

  assign sending = (state_reg == tone_pkg::TX_SEND);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tone_out_reg <= 1'b0;
      tone_oe_reg  <= 1'b1;
    end else if (output_mode_field_reg == tone_pkg::MODE_CONT) begin
      tone_out_reg <= tone_phase_reg; // [R10]
      tone_oe_reg  <= 1'b1;
    end else if (sending) begin
      tone_out_reg <= bit_gate & tone_phase_reg; // [R1] [R9]
      tone_oe_reg  <= 1'b1;
    end else if (output_mode_field_reg == tone_pkg::MODE_BURST) begin
      // Released only while idle, never between queued symbols, so a message is never cut short
      tone_out_reg <= 1'b0;
      tone_oe_reg  <= 1'b0; // [R11]
    end else begin
      tone_out_reg <= (output_mode_field_reg == tone_pkg::MODE_HIGH); // [R10]
      tone_oe_reg  <= 1'b1;
    end
  end

  assign tone_out = tone_out_reg;
  assign tone_oe  = tone_oe_reg;

endmodule : lnb_tone_burst_modulator

// ===== src/tone_pkg.sv
/*
  Constants for the LNB tone modulator: register offsets, field positions, reset values,
  tone timing and symbol shaping counts.
  Assumes a single 200 MHz system clock and the chip register port in front of it.
*/
// Function
// R1 - Output is a gated square wave at tone frequency, not level coding.
// R2 - Each byte goes MSB first then odd parity: nine bits, odd ones.
// R3 - Every bit lasts exactly thirty-three tone periods, shaped by gated tone width.
// R4 - Zero shape select high: zero is 22 periods tone, 11 silent.
// R5 - Zero shape select low: zero is tone for all 33 periods.
// R6 - One is 11 periods tone then 22 silent, either shape setting.
// R7 - One all-ones byte gives nine 0.5 ms bursts, eight 1 ms gaps.
// R8 - Shape low plus one zero byte gives 12.5 ms continuous tone.
// R9 - Active tone drives the pin fully high and low alternately.
// R10 - Mode 00/01 with empty queue holds 0/1; mode 11 continuous tone.
// R11 - Mode 10 releases the pin to high impedance after transmission completes.
// R12 - Software fills queue over registers; empty and full flags; no write when full.
// R13 - After reset queue empty, empty flag 1, full 0; first byte starts sending.
// R14 - After the last queued byte the modulator returns idle by itself.
// R15 - Waiting bytes follow the previous symbol on the next period, no gap.
package tone_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] CTRL_OFFSET   = 8'h08;
  localparam logic [7:0] FIFO_OFFSET   = 8'h09;
  localparam logic [7:0] STATUS_OFFSET = 8'h0A;

  localparam int MODE_LSB       = 0;
  localparam int ZERO_SHAPE_BIT = 2;
  localparam int EMPTY_BIT      = 0;
  localparam int FULL_BIT       = 1;
  localparam int BUSY_BIT       = 2;

  localparam logic [1:0] MODE_RESET       = 2'h0;
  localparam logic       ZERO_SHAPE_RESET = 1'b0;

  localparam logic [1:0] MODE_LOW    = 2'h0;
  localparam logic [1:0] MODE_HIGH   = 2'h1;
  localparam logic [1:0] MODE_BURST  = 2'h2;
  localparam logic [1:0] MODE_CONT   = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Queue
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW    = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam longint CLK_HZ  = 200_000_000;
  localparam longint TONE_HZ = 22_000;
  // Half tone period rounded down so the tone is never slower than asked
  localparam int HALF_PERIOD_CYCLES = int'(CLK_HZ / (2 * TONE_HZ));

  localparam logic [5:0] BIT_PERIODS   = 6'd33;
  localparam logic [5:0] SHORT_PERIODS = 6'd11;
  localparam logic [5:0] LONG_PERIODS  = 6'd22;
  localparam logic [3:0] SYMBOL_BITS   = 4'd9;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } tx_state_t;

endpackage : tone_pkg

// ===== src/tone_fifo_if.sv
/*
  Bundle between the modulator top and its byte queue.
  Push may also be raised while full is high; the queue drops such pushes.
*/
`timescale 1ns/1ps
interface tone_fifo_if;
  logic       push;
  logic [7:0] push_data;
  logic       pop;
  logic [7:0] pop_data;
  logic       empty;
  logic       full;

  modport producer (output push, output push_data, output pop,
                    input pop_data, input empty, input full);
  modport store    (input push, input push_data, input pop,
                    output pop_data, output empty, output full);
endinterface : tone_fifo_if

// ===== src/tone_fifo.sv
/*
  Byte queue in flip-flops for the tone modulator.
  Assumes the producer never pops when empty; pushes while full are dropped.
*/
`timescale 1ns/1ps
module tone_fifo (
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  // Queue port
  tone_fifo_if.store  q
);

  logic [7:0]               mem_reg [tone_pkg::FIFO_DEPTH];
  logic [tone_pkg::FIFO_AW-1:0] wr_ptr_reg;
  logic [tone_pkg::FIFO_AW-1:0] rd_ptr_reg;
  logic [tone_pkg::FIFO_AW:0]   count_reg;
  logic                     do_push;
  logic                     do_pop;

  assign do_push    = q.push && (count_reg != (tone_pkg::FIFO_AW+1)'(tone_pkg::FIFO_DEPTH));
  assign do_pop     = q.pop && (count_reg != '0);
  assign q.pop_data = mem_reg[rd_ptr_reg];
  assign q.empty    = (count_reg == '0);
  assign q.full     = (count_reg == (tone_pkg::FIFO_AW+1)'(tone_pkg::FIFO_DEPTH));

  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= q.push_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0; // [R13]
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule : tone_fifo

// ===== testbench/tone_mod_chk.sv
/* Port checker for the tone modulator.
   Assumes single-cycle register strobes and a bind onto the top module. */
`timescale 1ns/1ps
module tone_mod_chk #(
  parameter int HALF_PERIOD_CYCLES = 4
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Tone pin
  input wire logic       tone_out,
  input wire logic       tone_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] ctrl_q;
  int         ctrl_age_reg;
  int         hi_n;
  int         lo_n;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      ctrl_q <= 3'h0;
    else if (reg_wr && reg_addr == 8'h08)
      ctrl_q <= reg_wdata[2:0];
  end
  // Cycles since the last control write, saturating
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      ctrl_age_reg <= 0;
    else if (reg_wr && reg_addr == 8'h08)
      ctrl_age_reg <= 0;
    else if (ctrl_age_reg < 1000)
      ctrl_age_reg <= ctrl_age_reg + 1;
  end
  // Run lengths of each pin level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_n <= 0;
      lo_n <= 0;
    end else begin
      hi_n <= tone_out ? hi_n + 1 : 0;
      lo_n <= tone_out ? 0 : lo_n + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Mode changes can cut a half short, so they are excluded
  property p_half_high;
    $fell(tone_out) && ctrl_q[1:0] != 2'h1 && ctrl_age_reg > HALF_PERIOD_CYCLES + 1
      |-> hi_n == HALF_PERIOD_CYCLES;
  endproperty
  a_half_high: assert property (p_half_high) else $error("tone high half wrong");
  property p_cont_low;
    $rose(tone_out) && ctrl_q[1:0] == 2'h3 && ctrl_age_reg > HALF_PERIOD_CYCLES + 1
      && lo_n <= 2 * HALF_PERIOD_CYCLES |-> lo_n == HALF_PERIOD_CYCLES;
  endproperty
  a_cont_low: assert property (p_cont_low) else $error("tone low half wrong");
  property p_oe_on;
    ctrl_q[1:0] != 2'h2 && $past(ctrl_q[1:0]) != 2'h2 |-> tone_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("pin not driven");
  property p_hiz_quiet;
    !tone_oe |-> !tone_out;
  endproperty
  a_hiz_quiet: assert property (p_hiz_quiet) else $error("released pin active");
  property p_unmapped_zero;
    reg_rd && reg_addr != 8'h08 && reg_addr != 8'h0A |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("bad read");
  property p_ctrl_readback;
    reg_rd && !reg_wr && reg_addr == 8'h08 |=> reg_rdata == {5'h00, ctrl_q};
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback) else $error("ctrl read");
  property p_rdata_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_push_visible;
    reg_wr && reg_addr == 8'h09 ##1 reg_rd && reg_addr == 8'h0A |=> !reg_rdata[0];
  endproperty
  a_push_visible: assert property (p_push_visible) else $error("still empty");
  property p_status_form;
    reg_rd && reg_addr == 8'h0A |=> reg_rdata[7:3] == 5'h00 && reg_rdata[1:0] != 2'h3;
  endproperty
  a_status_form: assert property (p_status_form) else $error("status form");
  c_full: cover property (reg_rdata[1]);
  c_release: cover property ($fell(tone_oe));
  c_cont: cover property ($rose(tone_out) && ctrl_q[1:0] == 2'h3);
endmodule : tone_mod_chk

bind lnb_tone_burst_modulator tone_mod_chk #(.HALF_PERIOD_CYCLES(HALF_PERIOD_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tone_out(tone_out),
  .tone_oe(tone_oe));

// ===== testbench/lnb_rx_model.sv
/* Receiving LNB: measures gated tone bursts and decodes pulse widths.
   Assumes the pin is read only while driven; a long silence closes a burst. */
`timescale 1ns/1ps
module lnb_rx_model #(
  parameter int HALF_PERIOD_CYCLES = 4
) (
  input wire logic sys_clk,
  input wire logic tone_out,
  input wire logic tone_oe
);
  int         lens[$];
  logic [8:0] syms[$];
  logic [8:0] sh = 9'h000;
  int         rises = 0;
  int         quiet = 0;
  int         nb = 0;
  int         cyc = 0;
  int         first_rise = -1;
  int         last_rise = 0;
  logic       prev = 1'b0;
  always @(posedge sys_clk) begin
    cyc++;
    if (tone_oe && tone_out && !prev) begin
      rises++;
      quiet = 0;
      if (first_rise < 0)
        first_rise = cyc;
      last_rise = cyc;
    end else
      quiet++;
    // Short burst is a one, longer is a zero
    if (quiet == 4 * HALF_PERIOD_CYCLES && rises > 0) begin
      lens.push_back(rises);
      sh = {sh[7:0], rises < 17};
      nb++;
      if (nb == 9) begin
        syms.push_back(sh);
        nb = 0;
      end
      rises = 0;
    end
    prev = tone_out;
  end
  task clear;
    lens.delete();
    syms.delete();
    nb = 0;
    first_rise = -1;
  endtask : clear
endmodule : lnb_rx_model

// ===== testbench/lnb_tone_burst_modulator_tb_top.sv
/* Register-level tests of the tone modulator with a receiving LNB model.
   Assumes the checker is bound and a shortened half period. */
`timescale 1ns/1ps
module lnb_tone_burst_modulator_tb_top;
  localparam int HP = 4;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       tone_out;
  logic       tone_oe;
  logic [7:0] s;
  logic [7:0] d;
  int         n_errors = 0;
  int         num_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  lnb_tone_burst_modulator #(.HALF_PERIOD_CYCLES(HP)) u_dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tone_out(tone_out), .tone_oe(tone_oe));
  lnb_rx_model #(.HALF_PERIOD_CYCLES(HP)) u_rx (.sys_clk(sys_clk), .tone_out(tone_out),
    .tone_oe(tone_oe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk_n(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      n_errors++;
      $display("[ERR] %0t count %0d exp %0d", $time, got, exp);
    end
  endtask : chk_n
  // Leading wait keeps back-to-back writes from re-driving the strobe in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    @(posedge sys_clk);
    #1 v = reg_rdata;
    @(negedge sys_clk);
  endtask : rd
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a, s);
    chk8(s, exp);
  endtask : rdchk
  task automatic idle;
    s = 8'h00;
    for (int i = 0; i < 30000 && s !== 8'h01; i++)
      rd(8'h0A, s);
    repeat (40) @(negedge sys_clk);
  endtask : idle
  task end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    rdchk(8'h0A, 8'h01);
    rdchk(8'h09, 8'h00);
    rdchk(8'h3C, 8'h00);
    wr(8'h08, 8'h01);
    rdchk(8'h08, 8'h01);
    chk8({6'h00, tone_oe, tone_out}, 8'h03);
    wr(8'h08, 8'h00);
    repeat (3) @(negedge sys_clk);
    chk8({6'h00, tone_oe, tone_out}, 8'h02);
    wr(8'h08, 8'h03);
    repeat (60) @(negedge sys_clk);
    $display("static and continuous modes done");
    wr(8'h08, 8'h06);
    // Let the model close the leftover continuous burst first
    repeat (24) @(negedge sys_clk);
    u_rx.clear();
    wr(8'h09, 8'hFF);
    rd(8'h0A, s);
    chk8(s & 8'h03, 8'h00);
    idle();
    chk_n(u_rx.lens.size(), 9);
    foreach (u_rx.lens[i]) chk_n(u_rx.lens[i], 11);
    chk8({6'h00, tone_oe, tone_out}, 8'h00);
    $display("modulated burst done");
    wr(8'h08, 8'h02);
    u_rx.clear();
    wr(8'h09, 8'h00);
    idle();
    chk_n(u_rx.lens.size(), 1);
    // Eight zero bits of full tone, then the parity one bit
    chk_n(u_rx.lens[0], 8 * 33 + 11);
    $display("unmodulated burst done");
    wr(8'h08, 8'h06);
    u_rx.clear();
    for (int i = 0; i < 9; i++) wr(8'h09, 8'hA5 + 8'(i) * 8'h1F);
    rd(8'h0A, s);
    chk8(s & 8'h03, 8'h02);
    wr(8'h09, 8'h77);
    idle();
    chk_n(u_rx.syms.size(), 9);
    for (int i = 0; i < 9; i++) begin
      d = 8'hA5 + 8'(i) * 8'h1F;
      chk_n(int'(u_rx.syms[i]), int'({d, ~^d}));
    end
    // Eight symbols of 297 periods, eight bits of 33, last zero ends tone at period 21
    chk_n(u_rx.last_rise - u_rx.first_rise, 2661 * 2 * HP);
    rdchk(8'h0A, 8'h01);
    $display("queued message done");
    end_sim();
  end
endmodule : lnb_tone_burst_modulator_tb_top
